/* File: pkg/pfrb_map.svh */
/*
   pfrb_map.svh: register offsets, field positions, reset values and counts
   of the feedback divider register bank.
   assumes: included by bare name wherever a constant is needed.
*/
`ifndef PFRB_MAP_SVH
`define PFRB_MAP_SVH

// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define PFRB_OFS_INTEGER 8'h11
`define PFRB_OFS_FRAC_HIGH 8'h12
`define PFRB_OFS_FRAC_MID 8'h13
`define PFRB_OFS_FRAC_LOW 8'h14
`define PFRB_OFS_CTRL_PRIMARY 8'h15
`define PFRB_OFS_CTRL_ALIAS 8'h50

// ---------------------------------------------------------------
// field positions
// ---------------------------------------------------------------
`define PFRB_INT_MSB 5
`define PFRB_BIT_OE 7
`define PFRB_BIT_APPLY_FREQ 2
`define PFRB_BIT_APPLY_SMALL 1
`define PFRB_BIT_RESTORE 0

// ---------------------------------------------------------------
// reset values and counts
// ---------------------------------------------------------------
`define PFRB_CTRL_BIT_RESET 1'b0
`define PFRB_READ_NONE 8'h00
`define PFRB_INT_PAD 2'h0
`define PFRB_BIT_LAST 3'h7
`define PFRB_BIT_FIRST 3'h0
`define PFRB_PTR_STEP 8'h01

`endif

/* File: pkg/pfrb_pkg.sv */
/*
   pfrb_pkg: types shared by the register bank and its two-wire slave.
   assumes: the constants of pfrb_map.svh are included where used.
*/
package pfrb_pkg;

   // divider setting, user copy and working copy alike
   typedef struct packed {
      logic [5:0] whole;
      logic [23:0] fraction;
   } pfrb_divider_type;

   // one register write from the serial slave
   typedef struct packed {
      logic wr;
      logic [7:0] addr;
      logic [7:0] data;
   } pfrb_bus_type;

   typedef enum logic [2:0] {
      PFRB_IDLE,
      PFRB_ADDR,
      PFRB_ADDR_ACK,
      PFRB_WRITE,
      PFRB_WRITE_ACK,
      PFRB_READ,
      PFRB_READ_ACK
   } pfrb_i2c_state_type;

   typedef struct packed {
      pfrb_i2c_state_type state;
      logic sclMeta;
      logic sclSync;
      logic sclLast;
      logic sdaMeta;
      logic sdaSync;
      logic sdaLast;
      logic [7:0] shift;
      logic [2:0] bitCnt;
      logic full;
      logic rw;
      logic first;
      logic nack;
      logic sdaOeN;
      logic [7:0] ptr;
      pfrb_bus_type bus;
   } pfrb_i2c_regs_type;

   typedef struct packed {
      pfrb_divider_type user;
      pfrb_divider_type work;
      logic oeBit;
      logic applyFreq;
      logic applySmall;
      logic restore;
      logic loaded;
      logic calStart;
      logic stepStart;
      logic oeMeta;
      logic oeSync;
   } pfrb_bank_regs_type;

endpackage

/* File: hdl/pfrb_i2c_slave.sv */
/*
   pfrb_i2c_slave: two-wire serial slave; first written byte sets the
   register pointer, later bytes write or read with auto increment.
   assumes: scl and sda arrive straight from pins; rdata answers rdAddr
   combinationally in the same clock domain; reset already synchronised.
*/
`timescale 1ns/1ps
`include "pfrb_map.svh"

module pfrb_i2c_slave
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic rstSync_b,
   // serial pins
   input wire logic scl,
   input wire logic sdaIn,
   output logic sdaOut,
   output logic sdaOeN,
   input wire logic [6:0] slaveAddr,
   // register side
   output pfrb_pkg::pfrb_bus_type bus,
   output logic [7:0] rdAddr,
   input wire logic [7:0] rdata
);

   pfrb_pkg::pfrb_i2c_regs_type s;
   pfrb_pkg::pfrb_i2c_regs_type next_s;
   logic rise;
   logic fall;
   logic start;
   logic stop;

   // ---------------------------------------------------------------
   // next state
   // ---------------------------------------------------------------
   always_comb
   begin
      next_s = s;
      // only the second and third stages of each synchroniser feed any logic
      next_s.sclMeta = scl;
      next_s.sclSync = s.sclMeta;
      next_s.sclLast = s.sclSync;
      next_s.sdaMeta = sdaIn;
      next_s.sdaSync = s.sdaMeta;
      next_s.sdaLast = s.sdaSync;
      next_s.bus.wr = 1'b0;
      rise = s.sclSync && !s.sclLast;
      fall = !s.sclSync && s.sclLast;
      start = s.sclSync && s.sclLast && s.sdaLast && !s.sdaSync;
      stop = s.sclSync && s.sclLast && !s.sdaLast && s.sdaSync;
      if (start)
      begin
         next_s.state = pfrb_pkg::PFRB_ADDR;
         next_s.bitCnt = `PFRB_BIT_FIRST;
         next_s.full = 1'b0;
         next_s.first = 1'b1;
         next_s.sdaOeN = 1'b1;
      end
      else if (stop)
      begin
         next_s.state = pfrb_pkg::PFRB_IDLE;
         next_s.sdaOeN = 1'b1;
      end
      else if (rise)
      begin
         case (s.state)
            pfrb_pkg::PFRB_ADDR, pfrb_pkg::PFRB_WRITE, pfrb_pkg::PFRB_READ:
            begin
               if (s.state != pfrb_pkg::PFRB_READ)
               begin
                  next_s.shift = {s.shift[6:0], s.sdaSync};
               end
               next_s.bitCnt = s.bitCnt + 3'h1;
               next_s.full = (s.bitCnt == `PFRB_BIT_LAST);
            end
            pfrb_pkg::PFRB_READ_ACK:
            begin
               next_s.nack = s.sdaSync;
            end
            default:
            begin
               next_s.nack = s.nack;
            end
         endcase
      end
      else if (fall)
      begin
         case (s.state)
            pfrb_pkg::PFRB_ADDR:
            begin
               if (s.full)
               begin
                  next_s.full = 1'b0;
                  if (s.shift[7:1] == slaveAddr)
                  begin
                     next_s.sdaOeN = 1'b0;
                     next_s.rw = s.shift[0];
                     next_s.state = pfrb_pkg::PFRB_ADDR_ACK;
                  end
                  else
                  begin
                     next_s.state = pfrb_pkg::PFRB_IDLE;
                  end
               end
            end
            pfrb_pkg::PFRB_ADDR_ACK, pfrb_pkg::PFRB_READ_ACK:
            begin
               next_s.bitCnt = `PFRB_BIT_FIRST;
               if (s.state == pfrb_pkg::PFRB_READ_ACK && s.nack)
               begin
                  next_s.sdaOeN = 1'b1;
                  next_s.state = pfrb_pkg::PFRB_IDLE;
               end
               else if (s.rw)
               begin
                  // open drain: a one is sent by letting go of the line
                  next_s.shift = rdata;
                  next_s.sdaOeN = rdata[7];
                  next_s.state = pfrb_pkg::PFRB_READ;
               end
               else
               begin
                  next_s.sdaOeN = 1'b1;
                  next_s.state = pfrb_pkg::PFRB_WRITE;
               end
            end
            pfrb_pkg::PFRB_WRITE:
            begin
               if (s.full)
               begin
                  next_s.full = 1'b0;
                  next_s.sdaOeN = 1'b0;
                  next_s.state = pfrb_pkg::PFRB_WRITE_ACK;
                  next_s.first = 1'b0;
                  if (s.first)
                  begin
                     next_s.ptr = s.shift;
                  end
                  else
                  begin
                     next_s.bus.wr = 1'b1;
                     next_s.bus.addr = s.ptr;
                     next_s.bus.data = s.shift;
                     next_s.ptr = s.ptr + `PFRB_PTR_STEP;
                  end
               end
            end
            pfrb_pkg::PFRB_WRITE_ACK:
            begin
               next_s.sdaOeN = 1'b1;
               next_s.state = pfrb_pkg::PFRB_WRITE;
            end
            pfrb_pkg::PFRB_READ:
            begin
               if (s.full)
               begin
                  next_s.full = 1'b0;
                  next_s.sdaOeN = 1'b1;
                  next_s.ptr = s.ptr + `PFRB_PTR_STEP;
                  next_s.state = pfrb_pkg::PFRB_READ_ACK;
               end
               else
               begin
                  next_s.shift = {s.shift[6:0], 1'b0};
                  next_s.sdaOeN = s.shift[6];
               end
            end
            default:
            begin
               next_s.sdaOeN = 1'b1;
            end
         endcase
      end
   end

   always_ff @(posedge sys_clk or negedge rstSync_b)
   begin
      if (!rstSync_b)
      begin
         s <= '0;
         s.sclMeta <= 1'b1;
         s.sclSync <= 1'b1;
         s.sclLast <= 1'b1;
         s.sdaMeta <= 1'b1;
         s.sdaSync <= 1'b1;
         s.sdaLast <= 1'b1;
         s.sdaOeN <= 1'b1;
         s.state <= pfrb_pkg::PFRB_IDLE;
      end
      else
      begin
         s <= next_s;
      end
   end

   assign sdaOut = 1'b0;
   assign sdaOeN = s.sdaOeN;
   assign bus = s.bus;
   assign rdAddr = s.ptr;

endmodule

/* File: hdl/pfrb_register_bank.sv */
/*
   pfrb_register_bank: feedback divider and control registers of the
   oscillator synthesiser, reached over the two-wire serial pins.
   assumes: nvmDefaults holds the stored divider values and is stable
   from reset onward; calDone and stepDone are pulses from the synthesiser
   on sys_clk; oePin, scl and sda are raw pins.
*/
`timescale 1ns/1ps
`include "pfrb_map.svh"

module pfrb_register_bank
(
   // clock and reset
   input wire logic sys_clk,
   input wire logic rst_b,
   // serial pins
   input wire logic scl,
   input wire logic sdaIn,
   output logic sdaOut,
   output logic sdaOeN,
   input wire logic [6:0] slaveAddr,
   // stored defaults
   input wire pfrb_pkg::pfrb_divider_type nvmDefaults,
   // output buffer
   input wire logic oePin,
   output logic outputEnable,
   // synthesiser
   output pfrb_pkg::pfrb_divider_type pllWorking,
   output logic calStart,
   output logic stepStart,
   input wire logic calDone,
   input wire logic stepDone
);

   logic rstMeta_b;
   logic rstSync_b;
   pfrb_pkg::pfrb_bank_regs_type s;
   pfrb_pkg::pfrb_bank_regs_type next_s;
   pfrb_pkg::pfrb_bus_type bus;
   logic [7:0] rdAddr;
   logic [7:0] rdata;
   logic ctrlWrite;

   // ---------------------------------------------------------------
   // read decode
   // ---------------------------------------------------------------
   function automatic logic isCtrl(input logic [7:0] addr);
      // both offsets decode to one register
      isCtrl = (addr == `PFRB_OFS_CTRL_PRIMARY) || (addr == `PFRB_OFS_CTRL_ALIAS);
   endfunction

   function automatic logic [7:0] readReg(input pfrb_pkg::pfrb_bank_regs_type r,
                                          input logic [7:0] addr);
      readReg = `PFRB_READ_NONE;
      if (addr == `PFRB_OFS_INTEGER)
      begin
         readReg = {`PFRB_INT_PAD, r.user.whole};
      end
      else if (addr == `PFRB_OFS_FRAC_HIGH)
      begin
         readReg = r.user.fraction[23:16];
      end
      else if (addr == `PFRB_OFS_FRAC_MID)
      begin
         readReg = r.user.fraction[15:8];
      end
      else if (addr == `PFRB_OFS_FRAC_LOW)
      begin
         readReg = r.user.fraction[7:0];
      end
      else if (isCtrl(addr))
      begin
         readReg[`PFRB_BIT_OE] = r.oeBit;
         readReg[`PFRB_BIT_APPLY_FREQ] = r.applyFreq;
         readReg[`PFRB_BIT_APPLY_SMALL] = r.applySmall;
         readReg[`PFRB_BIT_RESTORE] = r.restore;
      end
   endfunction

   // ---------------------------------------------------------------
   // reset release
   // ---------------------------------------------------------------
   always_ff @(posedge sys_clk or negedge rst_b)
   begin
      if (!rst_b)
      begin
         rstMeta_b <= 1'b0;
         rstSync_b <= 1'b0;
      end
      else
      begin
         rstMeta_b <= 1'b1;
         rstSync_b <= rstMeta_b;
      end
   end

   // ---------------------------------------------------------------
   // serial slave
   // ---------------------------------------------------------------
   // pointer auto increment gives multi byte access
   pfrb_i2c_slave slave
   (
      .sys_clk(sys_clk),
      .rstSync_b(rstSync_b),
      .scl(scl),
      .sdaIn(sdaIn),
      .sdaOut(sdaOut),
      .sdaOeN(sdaOeN),
      .slaveAddr(slaveAddr),
      .bus(bus),
      .rdAddr(rdAddr),
      .rdata(rdata)
   );

   assign rdata = readReg(s, rdAddr);
   assign ctrlWrite = bus.wr && isCtrl(bus.addr);

   // ---------------------------------------------------------------
   // register state
   // ---------------------------------------------------------------
   always_comb
   begin
      next_s = s;
      next_s.oeMeta = oePin;
      next_s.oeSync = s.oeMeta;
      next_s.calStart = 1'b0;
      next_s.stepStart = 1'b0;
      // first cycle after release catches the stored values
      if (!s.loaded)
      begin
         next_s.user = nvmDefaults;
         next_s.work = nvmDefaults;
         next_s.loaded = 1'b1;
      end
      // calibration finished ends the frequency apply
      if (s.applyFreq && calDone)
      begin
         next_s.applyFreq = 1'b0;
      end
      // step finished ends the small step apply
      if (s.applySmall && stepDone)
      begin
         next_s.applySmall = 1'b0;
      end
      // restore reloads user values, done in one cycle
      if (s.restore)
      begin
         next_s.user = nvmDefaults;
         next_s.restore = 1'b0;
      end
      if (bus.wr)
      begin
         // only the low six bits are stored
         if (bus.addr == `PFRB_OFS_INTEGER)
         begin
            next_s.user.whole = bus.data[`PFRB_INT_MSB:0];
         end
         if (bus.addr == `PFRB_OFS_FRAC_HIGH)
         begin
            next_s.user.fraction[23:16] = bus.data;
         end
         if (bus.addr == `PFRB_OFS_FRAC_MID)
         begin
            next_s.user.fraction[15:8] = bus.data;
         end
         if (bus.addr == `PFRB_OFS_FRAC_LOW)
         begin
            next_s.user.fraction[7:0] = bus.data;
         end
      end
      if (ctrlWrite)
      begin
         // apply and restore bits only set by writes, a written zero is ignored; the enable bit takes the written value
         next_s.oeBit = bus.data[`PFRB_BIT_OE];
         // set wins over a same cycle done
         if (bus.data[`PFRB_BIT_APPLY_FREQ])
         begin
            next_s.applyFreq = 1'b1;
            if (!s.applyFreq)
            begin
               next_s.work = s.user;
               next_s.calStart = 1'b1;
            end
         end
         if (bus.data[`PFRB_BIT_APPLY_SMALL])
         begin
            next_s.applySmall = 1'b1;
            if (!s.applySmall)
            begin
               next_s.work = s.user;
               next_s.stepStart = 1'b1;
            end
         end
         if (bus.data[`PFRB_BIT_RESTORE])
         begin
            next_s.restore = 1'b1;
         end
      end
   end

   always_ff @(posedge sys_clk or negedge rstSync_b)
   begin
      if (!rstSync_b)
      begin
         s <= '0;
         s.oeBit <= `PFRB_CTRL_BIT_RESET;
      end
      else
      begin
         s <= next_s;
      end
   end

   // ---------------------------------------------------------------
   // outputs
   // ---------------------------------------------------------------
   // either source turns the buffer on
   assign outputEnable = s.oeSync || s.oeBit;
   assign pllWorking = s.work;
   assign calStart = s.calStart;
   assign stepStart = s.stepStart;

   // ---------------------------------------------------------------
   // checks
   // ---------------------------------------------------------------
   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!rstSync_b);

   // read data handed to the slave, as formed by the decode function
   a_ctrl_alias_read: assert property
      ((rdAddr == `PFRB_OFS_CTRL_PRIMARY || rdAddr == `PFRB_OFS_CTRL_ALIAS)
         |-> rdata[`PFRB_BIT_OE] == s.oeBit
         && rdata[`PFRB_BIT_APPLY_FREQ] == s.applyFreq
         && rdata[`PFRB_BIT_APPLY_SMALL] == s.applySmall
         && rdata[`PFRB_BIT_RESTORE] == s.restore)
      else $error("control read differs from register");
   a_oe_alias_write: assert property
      (ctrlWrite |=> s.oeBit == $past(bus.data[`PFRB_BIT_OE]))
      else $error("enable bit not written");
   a_oe_pin_follow: assert property
      ($rose(oePin) |-> ##[2:3] outputEnable)
      else $error("pin did not enable output");
   a_integer_write: assert property
      (bus.wr && bus.addr == `PFRB_OFS_INTEGER |=>
         s.user.whole == $past(bus.data[`PFRB_INT_MSB:0])
         && readReg(s, `PFRB_OFS_INTEGER) == {`PFRB_INT_PAD, $past(bus.data[`PFRB_INT_MSB:0])})
      else $error("integer field wrong");
   a_fraction_mid: assert property
      (bus.wr && bus.addr == `PFRB_OFS_FRAC_MID |=> s.user.fraction[15:8] == $past(bus.data)
         && $stable(s.user.fraction[23:16]))
      else $error("fraction lane wrong");
   a_apply_copy: assert property
      (ctrlWrite && bus.data[`PFRB_BIT_APPLY_FREQ] && !s.applyFreq
         |=> s.applyFreq && calStart && pllWorking == $past(s.user))
      else $error("apply did not copy");
   a_apply_clear: assert property
      (s.applyFreq && calDone && !ctrlWrite |=> !s.applyFreq)
      else $error("apply bit not cleared");
   a_small_clear: assert property
      (s.applySmall && stepDone && !ctrlWrite |=> !s.applySmall ##0 !calStart)
      else $error("small step bit not cleared");
   a_restore_load: assert property
      (s.restore && !bus.wr |=> s.user == $past(nvmDefaults) && !s.restore)
      else $error("restore failed");
   a_startup_load: assert property
      ($rose(s.loaded) |-> s.user == $past(nvmDefaults) && s.work == $past(nvmDefaults))
      else $error("defaults not loaded");

   c_apply_done: cover property (s.applyFreq ##[1:200] !s.applyFreq);
   // step done comes back only after a full readback, several hundred cycles
   c_small_step: cover property (stepStart ##[1:1000] !s.applySmall);
   c_restore: cover property (s.restore ##1 !s.restore);
   c_alias_write: cover property (bus.wr && bus.addr == `PFRB_OFS_CTRL_ALIAS);

endmodule

/* File: verif/pfrb_i2c_host.sv */
/*
   pfrb_i2c_host: behavioural two-wire bus master for the register bank.
   assumes: sda is the wired level with a pull-up; steps on sys_clk edges.
*/
`timescale 1ns/1ps

module pfrb_i2c_host
#(
   parameter logic [6:0] DEV_ADDR = 7'h3a
)
(
   // clock
   input wire logic sys_clk,
   // bus pins
   output logic scl,
   output logic hostOeN,
   input wire logic sda,
   // read results
   output logic rdValid,
   output logic [7:0] rdByte,
   output logic [7:0] nackCnt
);
   // scl phases well above the six cycles the slave needs
   localparam int HALF = 8;

   initial
   begin
      scl = 1'b1;
      hostOeN = 1'b1;
      rdValid = 1'b0;
      rdByte = 8'h00;
      nackCnt = 8'h00;
   end

   task automatic w(input int n);
      repeat (n) @(posedge sys_clk);
   endtask

   // data changes only while scl is low
   task automatic bitCycle(input logic b, output logic s);
      w(HALF / 2);
      hostOeN <= b;
      w(HALF / 2);
      scl <= 1'b1;
      w(HALF);
      s = sda;
      scl <= 1'b0;
   endtask

   task automatic startCond();
      w(HALF / 2);
      hostOeN <= 1'b1;
      w(HALF / 2);
      scl <= 1'b1;
      w(HALF);
      hostOeN <= 1'b0;
      w(HALF);
      scl <= 1'b0;
   endtask

   task automatic stopCond();
      w(HALF / 2);
      hostOeN <= 1'b0;
      w(HALF / 2);
      scl <= 1'b1;
      w(HALF);
      hostOeN <= 1'b1;
      w(HALF);
   endtask

   task automatic sendByte(input logic [7:0] d);
      logic s;
      for (int i = 7; i >= 0; i--)
         bitCycle(d[i], s);
      bitCycle(1'b1, s);
      if (s !== 1'b0)
         nackCnt <= nackCnt + 8'h01;
   endtask

   task automatic getByte(input logic last);
      logic [7:0] d;
      logic s;
      for (int i = 7; i >= 0; i--)
      begin
         bitCycle(1'b1, s);
         d[i] = s;
      end
      bitCycle(last, s);
      rdByte <= d;
      rdValid <= 1'b1;
      w(1);
      rdValid <= 1'b0;
   endtask

   task automatic writeRegs(input logic [7:0] ptr, input logic [7:0] q[$]);
      startCond();
      sendByte({DEV_ADDR, 1'b0});
      sendByte(ptr);
      foreach (q[i])
         sendByte(q[i]);
      stopCond();
   endtask

   task automatic readRegs(input logic [7:0] ptr, input int n);
      startCond();
      sendByte({DEV_ADDR, 1'b0});
      sendByte(ptr);
      startCond();
      sendByte({DEV_ADDR, 1'b1});
      for (int i = 0; i < n; i++)
         getByte(i == n - 1);
      stopCond();
   endtask
endmodule

/* File: verif/pfrb_register_bank_tb.sv */
/*
   pfrb_register_bank_tb: self-checking bench of the register bank.
   assumes: the host model drives the serial pins; synthesiser done pulses
   come from the main sequence.
*/
`timescale 1ns/1ps

module pfrb_register_bank_tb;
   typedef logic [7:0] pfrb_byteq_type[$];
   logic sys_clk, rst_b, scl, hostOeN, sdaOut, sdaOeN, sda;
   logic oePin, outputEnable, calStart, stepStart, calDone, stepDone;
   logic rdValid;
   logic [7:0] rdByte, nackCnt;
   pfrb_pkg::pfrb_divider_type nvm, user, pllWorking;
   logic [7:0] expQ[$];
   logic [31:0] seed;
   int errorCnt, samplesChecked, calCnt, stepCnt;

   // open drain: either party pulls low
   assign sda = (sdaOeN | sdaOut) & hostOeN;

   pfrb_register_bank dut_u
   (
      .sys_clk(sys_clk), .rst_b(rst_b), .scl(scl), .sdaIn(sda),
      .sdaOut(sdaOut), .sdaOeN(sdaOeN), .slaveAddr(7'h3a), .nvmDefaults(nvm),
      .oePin(oePin), .outputEnable(outputEnable), .pllWorking(pllWorking),
      .calStart(calStart), .stepStart(stepStart), .calDone(calDone),
      .stepDone(stepDone)
   );

   pfrb_i2c_host host_u
   (
      .sys_clk(sys_clk), .scl(scl), .hostOeN(hostOeN), .sda(sda),
      .rdValid(rdValid), .rdByte(rdByte), .nackCnt(nackCnt)
   );

   // ---------------------------------------------------------------
   // helpers
   // ---------------------------------------------------------------
   function automatic logic [31:0] xs(input logic [31:0] v);
      logic [31:0] x;
      x = v ^ (v << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction

   function automatic pfrb_byteq_type divBytes(input pfrb_pkg::pfrb_divider_type d);
      pfrb_byteq_type q;
      q.push_back({2'h0, d.whole});
      q.push_back(d.fraction[23:16]);
      q.push_back(d.fraction[15:8]);
      q.push_back(d.fraction[7:0]);
      return q;
   endfunction

   task automatic put1(input logic [7:0] ptr, input logic [7:0] v);
      pfrb_byteq_type q;
      q.push_back(v);
      host_u.writeRegs(ptr, q);
   endtask

   task automatic get1(input logic [7:0] ptr, input logic [7:0] v);
      expQ.push_back(v);
      host_u.readRegs(ptr, 1);
   endtask

   task automatic getDiv(input pfrb_pkg::pfrb_divider_type d);
      expQ = {expQ, divBytes(d)};
      host_u.readRegs(8'h11, 4);
   endtask

   task automatic checkByte(input string what, input logic [7:0] exp, input logic [7:0] got);
      samplesChecked++;
      if (got !== exp)
      begin
         errorCnt++;
         $display("BAD %s expected %h seen %h", what, exp, got);
      end
   endtask

   task automatic checkDiv(input string what, input pfrb_pkg::pfrb_divider_type exp);
      samplesChecked++;
      if (pllWorking !== exp)
      begin
         errorCnt++;
         $display("BAD %s expected %h seen %h", what, exp, pllWorking);
      end
   endtask

   task automatic stopTest();
      $display("checks %0d mismatches %0d", samplesChecked, errorCnt);
      if (errorCnt == 0 && samplesChecked > 0)
         $display("No errors found");
      else
         $display("Errors were found");
      $finish;
   endtask

   // ---------------------------------------------------------------
   // clock, watchers, watchdog
   // ---------------------------------------------------------------
   initial
   begin
      sys_clk = 1'b0;
      forever #20 sys_clk = ~sys_clk;
   end

   always @(posedge sys_clk)
   begin
      if (rdValid === 1'b1)
         checkByte("read data", expQ.pop_front(), rdByte);
      if (calStart === 1'b1)
         calCnt++;
      if (stepStart === 1'b1)
         stepCnt++;
   end

   // about four times the length of the sequence
   initial
   begin
      #2000000;
      errorCnt++;
      stopTest();
   end

   // ---------------------------------------------------------------
   // main sequence
   // ---------------------------------------------------------------
   initial
   begin
      errorCnt = 0;
      samplesChecked = 0;
      calCnt = 0;
      stepCnt = 0;
      rst_b = 1'b0;
      oePin = 1'b0;
      calDone = 1'b0;
      stepDone = 1'b0;
      seed = xs(32'h000101a1);
      nvm = {6'h1c, seed[23:0]};
      repeat (20) @(posedge sys_clk);
      rst_b <= 1'b1;
      repeat (10) @(posedge sys_clk);
      checkDiv("working after reset", nvm);
      getDiv(nvm);
      get1(8'h15, 8'h00);
      seed = xs(seed);
      user = {6'h20, seed[23:0]};
      host_u.writeRegs(8'h11, divBytes(user));
      checkDiv("working before apply", nvm);
      getDiv(user);
      put1(8'h50, 8'h04);
      checkByte("cal pulses", 8'h01, 8'(calCnt));
      checkDiv("working after apply", user);
      get1(8'h15, 8'h04);
      put1(8'h15, 8'h04);
      checkByte("cal pulses on repeat", 8'h01, 8'(calCnt));
      calDone <= 1'b1;
      @(posedge sys_clk);
      calDone <= 1'b0;
      get1(8'h50, 8'h00);
      seed = xs(seed);
      user.fraction = seed[23:0];
      host_u.writeRegs(8'h11, divBytes(user));
      put1(8'h15, 8'h02);
      checkByte("step pulses", 8'h01, 8'(stepCnt));
      checkByte("cal pulses kept", 8'h01, 8'(calCnt));
      checkDiv("working after step", user);
      get1(8'h50, 8'h02);
      stepDone <= 1'b1;
      @(posedge sys_clk);
      stepDone <= 1'b0;
      get1(8'h15, 8'h00);
      put1(8'h15, 8'h80);
      checkByte("enable by bit", 8'h01, {7'h00, outputEnable});
      get1(8'h50, 8'h80);
      put1(8'h50, 8'h00);
      checkByte("enable cleared", 8'h00, {7'h00, outputEnable});
      oePin <= 1'b1;
      repeat (4) @(posedge sys_clk);
      checkByte("enable by pin", 8'h01, {7'h00, outputEnable});
      oePin <= 1'b0;
      repeat (4) @(posedge sys_clk);
      checkByte("enable pin off", 8'h00, {7'h00, outputEnable});
      put1(8'h15, 8'h01);
      getDiv(nvm);
      checkDiv("working kept by restore", user);
      get1(8'h50, 8'h00);
      get1(8'h30, 8'h00);
      checkByte("pending reads", 8'h00, 8'(expQ.size()));
      checkByte("refused bytes", 8'h00, nackCnt);
      stopTest();
   end
endmodule
